// File: verilog/smcs_top.sv
`timescale 1ns/1ps
// How it works
// - reset loads control register with f8, mp enable and timer select clear
// - bits 7 to 3 of control register ignore writes, read one
// - mp enable clear keeps mp framing off regardless of mode select
// - mp enable set plus mode mp select gives multiprocessor async frames
// - control bits 1 and 0 stored and forwarded as timer clock select
// - mode bit 7 picks async when zero, clocked sync when one
// - async mode bit 6 picks eight data bits at zero, seven at one
// - async mode bit 3 picks one stop bit at zero, two at one
// - parity enable adds parity bit; mp bit replaces parity when active
// - async receiver flags framing, parity, overrun and line break
// - sync mode uses eight bits, no mp, parity or stop bits
// - sync mode receive errors are overrun only
// - async, both clock bits zero: baud generator, clock pin unused
// - async, high zero low one: baud generator, pin outputs bit clock
// - async, high bit one: clock pin input at sixteen times bit rate
// - sync, high bit zero: baud generator, clock pin driven as output
// - sync, high bit one: shift on far side clock, no baud generator
// - baud prescale codes 0 to 3 divide clock by 1, 4, 16, 64
// - async receiver syncs on start edge, samples at count 8 of 16
module smcs_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    output logic      [1:0]  timer_clk_sel
);
    logic [7:0]  stc_reg;
    logic [7:0]  stc_next;
    logic [7:0]  mode_reg;
    logic [7:0]  mode_next;
    logic [7:0]  baud_reg;
    logic [7:0]  baud_next;
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        setup;
    logic        wr;
    logic        rd;
    logic        mapped;
    logic        is_sync;
    logic        mp_active;
    logic        parity_active;
    logic        char7;
    logic        stop2;
    logic        ext_clk;
    logic        sck_drive;
    logic        rx_en;
    logic        baud_tick;
    logic        sck_prev_reg;
    logic        sck_rise;
    logic        tick16;
    logic        sync_edge;
    logic        tog_ok;
    logic        sck_int_reg;
    logic        sck_int_next;
    logic [3:0]  bclk_reg;
    logic [3:0]  bclk_next;
    logic        sck_out_reg;
    logic        sck_out_next;
    logic        sck_oe_reg;
    smcs_pkg::smcs_rx_state_type state_reg;
    smcs_pkg::smcs_rx_state_type state_next;
    logic [3:0]  timer_counter_8b_reg;
    logic [3:0]  timer_counter_8b_next;
    logic [2:0]  bit_reg;
    logic [2:0]  bit_next;
    logic [7:0]  shift_reg;
    logic [7:0]  shift_next;
    logic        pbit_reg;
    logic        pbit_next;
    logic        stopn_reg;
    logic        stopn_next;
    logic        ferr_reg;
    logic        ferr_next;
    logic        deliver;
    logic        del_fer;
    logic        del_per;
    logic [7:0]  rx_word;
    logic [7:0]  rxdata_reg;
    logic [7:0]  rxdata_next;
    logic [5:0]  flag_reg;
    logic [5:0]  flag_next;
    logic [31:0] status_word;

    function automatic logic addr_hit(input logic [31:0] addr,
                                      input logic [15:0] idx);
        addr_hit = (addr[31:18] == 14'h0000) && (addr[17:2] == idx)
                   && (addr[1:0] == 2'h0);
    endfunction

    // effective frame format
    assign is_sync       = mode_reg[smcs_pkg::MD_SYNC];
    assign mp_active     = !is_sync && mode_reg[smcs_pkg::MD_MP_SEL]
                           && stc_reg[smcs_pkg::STC_MPE];
    assign parity_active = !is_sync && mode_reg[smcs_pkg::MD_PAR_EN]
                           && !mp_active;
    assign char7         = !is_sync && mode_reg[smcs_pkg::MD_CHAR7];
    assign stop2         = !is_sync && mode_reg[smcs_pkg::MD_STOP2];
    assign ext_clk       = ctrl_reg[smcs_pkg::CT_CKS_HI];
    assign sck_drive     = !ext_clk
                           && (is_sync || ctrl_reg[smcs_pkg::CT_CKS_LO]);
    assign rx_en         = ctrl_reg[smcs_pkg::CT_RX_EN];

    // baud generator is held stopped whenever the pin supplies the clock
    smcs_baud_gen u_baud (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (!ext_clk),
        .prescale (mode_reg[smcs_pkg::MD_PRE_HI:smcs_pkg::MD_PRE_LO]),
        .divisor  (baud_reg),
        .tick     (baud_tick)
    );

    // ---------------- apb slave: no wait states, read data registered
    assign setup = psel && !penable;
    assign wr    = psel && penable && pready_reg && pwrite;
    assign rd    = psel && penable && pready_reg && !pwrite;

    assign status_word = {17'h0_0000, sck_drive, ext_clk, stop2, mp_active,
                          parity_active, char7, is_sync, 2'h0, flag_reg};

    always_comb begin
        stc_next     = stc_reg;
        mode_next    = mode_reg;
        baud_next    = baud_reg;
        ctrl_next    = ctrl_reg;
        prdata_next  = prdata_reg;
        mapped       = 1'b1;
        if (addr_hit(paddr, smcs_pkg::STC_IDX)) begin
            prdata_next = {24'h00_0000, stc_reg | smcs_pkg::STC_ONES};
            if (wr) begin
                stc_next = (pwdata[7:0] & ~smcs_pkg::STC_ONES)
                           | smcs_pkg::STC_ONES;
            end
        end else if (addr_hit(paddr, smcs_pkg::MODE_IDX)) begin
            prdata_next = {24'h00_0000, mode_reg};
            if (wr) begin
                mode_next = pwdata[7:0];
            end
        end else if (addr_hit(paddr, smcs_pkg::BAUD_IDX)) begin
            prdata_next = {24'h00_0000, baud_reg};
            if (wr) begin
                baud_next = pwdata[7:0];
            end
        end else if (addr_hit(paddr, smcs_pkg::CTRL_IDX)) begin
            prdata_next = {24'h00_0000, ctrl_reg};
            if (wr) begin
                ctrl_next = pwdata[7:0];
            end
        end else if (addr_hit(paddr, smcs_pkg::STATUS_IDX)) begin
            prdata_next = status_word;
        end else if (addr_hit(paddr, smcs_pkg::RXDATA_IDX)) begin
            prdata_next = {24'h00_0000, rxdata_reg};
        end else begin
            prdata_next = 32'h0000_0000;
            mapped      = 1'b0;
        end
        if (!setup) begin
            prdata_next = prdata_reg;
        end
        pready_next  = setup;
        pslverr_next = setup && !mapped;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stc_reg     <= smcs_pkg::STC_RESET;
            mode_reg    <= smcs_pkg::MODE_RESET;
            baud_reg    <= smcs_pkg::BAUD_RESET;
            ctrl_reg    <= smcs_pkg::CTRL_RESET;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            stc_reg     <= stc_next;
            mode_reg    <= mode_next;
            baud_reg    <= baud_next;
            ctrl_reg    <= ctrl_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ---------------- serial clock pin and bit clocks
    assign sck_rise  = sck_in && !sck_prev_reg;
    assign tick16    = ext_clk ? sck_rise : baud_tick;
    assign tog_ok    = is_sync && !ext_clk && rx_en && (state_reg == smcs_pkg::RX_DATA);
    assign sync_edge = ext_clk ? sck_rise
                               : (baud_tick && tog_ok && !sck_int_reg);

    always_comb begin
        bclk_next    = tick16 ? bclk_reg + 4'h1 : bclk_reg;
        // internal sync clock idles high whenever tog_ok is low, and toggles on each baud tick otherwise
        sck_int_next = 1'b1;
        if (tog_ok) begin
            sck_int_next = baud_tick ? !sck_int_reg : sck_int_reg;
        end
        sck_out_next = is_sync ? sck_int_next : bclk_next[3];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // matches the idle-high pin so release gives no false edge
            sck_prev_reg <= 1'b1;
            sck_int_reg  <= 1'b1;
            bclk_reg     <= 4'h0;
            sck_out_reg  <= 1'b1;
            sck_oe_reg   <= 1'b0;
        end else begin
            sck_prev_reg <= sck_in;
            sck_int_reg  <= sck_int_next;
            bclk_reg     <= bclk_next;
            sck_out_reg  <= sck_out_next;
            sck_oe_reg   <= sck_drive;
        end
    end

    // ---------------- receiver sequencing
    assign rx_word = char7 ? {1'b0, shift_reg[7:1]} : shift_reg;

    always_comb begin
        state_next = state_reg;
        timer_counter_8b_next  = timer_counter_8b_reg;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        pbit_next  = pbit_reg;
        stopn_next = stopn_reg;
        ferr_next  = ferr_reg;
        deliver    = 1'b0;
        del_fer    = 1'b0;
        if (!rx_en) begin
            state_next = smcs_pkg::RX_IDLE;
        end else if (is_sync) begin
            case (state_reg)
                smcs_pkg::RX_DATA: begin
                    if (sync_edge) begin
                        shift_next = {rxd, shift_reg[7:1]};
                        bit_next   = bit_reg + 3'h1;
                        deliver    = (bit_reg == smcs_pkg::LAST_BIT_8);
                    end
                end
                default: begin
                    state_next = smcs_pkg::RX_DATA;
                    bit_next   = 3'h0;
                end
            endcase
        end else if (tick16) begin
            timer_counter_8b_next = timer_counter_8b_reg + 4'h1;
            case (state_reg)
                smcs_pkg::RX_IDLE: begin
                    if (!rxd) begin
                        state_next = smcs_pkg::RX_START;
                        timer_counter_8b_next  = 4'h0;
                    end
                end
                smcs_pkg::RX_START: begin
                    if (timer_counter_8b_reg == smcs_pkg::SAMPLE_TICK) begin
                        state_next = rxd ? smcs_pkg::RX_IDLE : smcs_pkg::RX_DATA;
                        bit_next   = 3'h0;
                        pbit_next  = 1'b0;
                        ferr_next  = 1'b0;
                        stopn_next = 1'b0;
                    end
                end
                smcs_pkg::RX_DATA: begin
                    if (timer_counter_8b_reg == smcs_pkg::SAMPLE_TICK) begin
                        shift_next = {rxd, shift_reg[7:1]};
                        bit_next   = bit_reg + 3'h1;
                        if (bit_reg == (char7 ? smcs_pkg::LAST_BIT_7
                                              : smcs_pkg::LAST_BIT_8)) begin
                            state_next = (parity_active || mp_active)
                                       ? smcs_pkg::RX_EXTRA : smcs_pkg::RX_STOP;
                        end
                    end
                end
                smcs_pkg::RX_EXTRA: begin
                    if (timer_counter_8b_reg == smcs_pkg::SAMPLE_TICK) begin
                        pbit_next  = rxd;
                        state_next = smcs_pkg::RX_STOP;
                    end
                end
                default: begin
                    if (timer_counter_8b_reg == smcs_pkg::SAMPLE_TICK) begin
                        ferr_next = ferr_reg || !rxd;
                        if (stop2 && !stopn_reg) begin
                            stopn_next = 1'b1;
                        end else begin
                            deliver    = 1'b1;
                            del_fer    = ferr_reg || !rxd;
                            state_next = smcs_pkg::RX_IDLE;
                        end
                    end
                end
            endcase
        end
        del_per = deliver && parity_active
                  && (^rx_word ^ pbit_reg ^ mode_reg[smcs_pkg::MD_PAR_ODD]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= smcs_pkg::RX_IDLE;
            timer_counter_8b_reg  <= 4'h0;
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
            pbit_reg  <= 1'b0;
            stopn_reg <= 1'b0;
            ferr_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_counter_8b_reg  <= timer_counter_8b_next;
            bit_reg   <= bit_next;
            shift_reg <= shift_next;
            pbit_reg  <= pbit_next;
            stopn_reg <= stopn_next;
            ferr_reg  <= ferr_next;
        end
    end

    // ---------------- receive flags; a new character beats a clear
    always_comb begin
        flag_next   = flag_reg;
        rxdata_next = rxdata_reg;
        if (wr && addr_hit(paddr, smcs_pkg::STATUS_IDX)) begin
            flag_next[smcs_pkg::ST_BRK:smcs_pkg::ST_OVR] =
                flag_reg[smcs_pkg::ST_BRK:smcs_pkg::ST_OVR]
                & ~pwdata[smcs_pkg::ST_BRK:smcs_pkg::ST_OVR];
        end
        if (rd && addr_hit(paddr, smcs_pkg::RXDATA_IDX)) begin
            flag_next[smcs_pkg::ST_FULL] = 1'b0;
        end
        if (deliver) begin
            if (flag_next[smcs_pkg::ST_FULL]) begin
                // unread character is kept, the new one is lost
                flag_next[smcs_pkg::ST_OVR] = 1'b1;
            end else begin
                rxdata_next                  = rx_word;
                flag_next[smcs_pkg::ST_FULL] = 1'b1;
                flag_next[smcs_pkg::ST_MPB]  = mp_active && pbit_reg;
                if (del_fer) begin
                    flag_next[smcs_pkg::ST_FER] = 1'b1;
                end
                if (del_per) begin
                    flag_next[smcs_pkg::ST_PER] = 1'b1;
                end
                if (del_fer && rx_word == 8'h00 && !pbit_reg) begin
                    flag_next[smcs_pkg::ST_BRK] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg   <= 6'h00;
            rxdata_reg <= 8'h00;
        end else begin
            flag_reg   <= flag_next;
            rxdata_reg <= rxdata_next;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign sck_out       = sck_out_reg;
    assign sck_oe        = sck_oe_reg;
    assign timer_clk_sel = stc_reg[smcs_pkg::STC_TCS_HI:smcs_pkg::STC_TCS_LO];

    // ---------------- checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stc_read;
        psel && !penable && !pwrite && addr_hit(paddr, smcs_pkg::STC_IDX);
    endsequence
    sequence s_answer;
        pready_reg ##1 !pready_reg;
    endsequence

    a_stc_ones_read: assert property (s_stc_read |=>
        pready_reg && prdata_reg[7:3] == 5'h1f && !pslverr_reg)
        else $error("control register high bits not read as one");
    a_stc_held: assert property (stc_reg[7:3] == 5'h1f)
        else $error("control register fixed bits lost");
    a_apb_wait: assert property (setup |=> s_answer)
        else $error("apb answer timing wrong");
    a_mp_gate: assert property (!stc_reg[smcs_pkg::STC_MPE] |-> !mp_active)
        else $error("mp framing active with enable clear");
    a_mp_on: assert property (stc_reg[smcs_pkg::STC_MPE] && !is_sync
        && mode_reg[smcs_pkg::MD_MP_SEL] |-> mp_active && !parity_active)
        else $error("mp format not selected");
    a_timer_sel: assert property (wr && addr_hit(paddr, smcs_pkg::STC_IDX)
        |=> timer_clk_sel == $past(pwdata[1:0]))
        else $error("timer clock select not forwarded");
    a_sck_pin: assert property (sck_drive ##1 sck_drive |-> sck_oe)
        else $error("clock pin not driven");
    a_ext_idle: assert property (ext_clk ##1 ext_clk |-> !baud_tick
        && !sck_oe)
        else $error("baud generator used with external clock");
    a_start_samp: assert property (state_reg == smcs_pkg::RX_START && rx_en
        && !is_sync && tick16 && timer_counter_8b_reg == smcs_pkg::SAMPLE_TICK && !rxd
        |=> state_reg == smcs_pkg::RX_DATA && bit_reg == 3'h0)
        else $error("start bit not sampled at count 8");
    a_char_len: assert property (state_reg == smcs_pkg::RX_DATA && char7
        |-> bit_reg <= smcs_pkg::LAST_BIT_7)
        else $error("seven bit character overran");
    a_sync_errs: assert property (is_sync |-> !del_fer && !del_per)
        else $error("sync mode reported framing or parity");
    a_overrun: assert property (deliver && flag_reg[smcs_pkg::ST_FULL]
        && !rd |=> flag_reg[smcs_pkg::ST_OVR] && $stable(rxdata_reg))
        else $error("overrun not flagged");
endmodule

// File: verilog/smcs_pkg.sv
package smcs_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] STC_IDX     = 16'hffc3;
    localparam logic [15:0] MODE_IDX    = 16'hffd8;
    localparam logic [15:0] BAUD_IDX    = 16'hffd9;
    localparam logic [15:0] CTRL_IDX    = 16'hffda;
    localparam logic [15:0] STATUS_IDX  = 16'hffdb;
    localparam logic [15:0] RXDATA_IDX  = 16'hffdc;

    localparam logic [7:0]  STC_RESET   = 8'hf8;
    localparam logic [7:0]  STC_ONES    = 8'hf8;
    localparam logic [7:0]  MODE_RESET  = 8'h00;
    localparam logic [7:0]  BAUD_RESET  = 8'hff;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;

    localparam int unsigned STC_MPE     = 2;
    localparam int unsigned STC_TCS_HI  = 1;
    localparam int unsigned STC_TCS_LO  = 0;

    localparam int unsigned MD_SYNC     = 7;
    localparam int unsigned MD_CHAR7    = 6;
    localparam int unsigned MD_PAR_EN   = 5;
    localparam int unsigned MD_PAR_ODD  = 4;
    localparam int unsigned MD_STOP2    = 3;
    localparam int unsigned MD_MP_SEL   = 2;
    localparam int unsigned MD_PRE_HI   = 1;
    localparam int unsigned MD_PRE_LO   = 0;

    localparam int unsigned CT_RX_EN    = 4;
    localparam int unsigned CT_CKS_HI   = 1;
    localparam int unsigned CT_CKS_LO   = 0;

    localparam int unsigned ST_FULL     = 0;
    localparam int unsigned ST_OVR      = 1;
    localparam int unsigned ST_FER      = 2;
    localparam int unsigned ST_PER      = 3;
    localparam int unsigned ST_BRK      = 4;
    localparam int unsigned ST_MPB      = 5;

    localparam logic [5:0]  PRE_LAST_1  = 6'h00;
    localparam logic [5:0]  PRE_LAST_4  = 6'h03;
    localparam logic [5:0]  PRE_LAST_16 = 6'h0f;
    localparam logic [5:0]  PRE_LAST_64 = 6'h3f;
    localparam logic [1:0]  QUART_LAST  = 2'h3;

    localparam logic [3:0]  SAMPLE_TICK = 4'h7;
    localparam logic [2:0]  LAST_BIT_8  = 3'h7;
    localparam logic [2:0]  LAST_BIT_7  = 3'h6;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_EXTRA,
        RX_STOP
    } smcs_rx_state_type;
endpackage

// File: verilog/smcs_baud_gen.sv
`timescale 1ns/1ps
module smcs_baud_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [1:0] prescale,
    input  wire logic [7:0] divisor,
    output logic            tick
);
    logic [5:0] pre_reg;
    logic [5:0] pre_next;
    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic [1:0] quart_reg;
    logic [1:0] quart_next;
    logic       tick_reg;
    logic       tick_next;

    function automatic logic [5:0] pre_last(input logic [1:0] code);
        case (code)
            2'h0:    pre_last = smcs_pkg::PRE_LAST_1;
            2'h1:    pre_last = smcs_pkg::PRE_LAST_4;
            2'h2:    pre_last = smcs_pkg::PRE_LAST_16;
            default: pre_last = smcs_pkg::PRE_LAST_64;
        endcase
    endfunction

    // tick every 4 * prescale factor (1, 4, 16 or 64 for codes 0 to 3) * (divisor + 1) clocks
    always_comb begin
        pre_next   = pre_reg;
        div_next   = div_reg;
        quart_next = quart_reg;
        tick_next  = 1'b0;
        if (!run) begin
            pre_next   = 6'h00;
            div_next   = 8'h00;
            quart_next = 2'h0;
        end else if (pre_reg >= pre_last(prescale)) begin
            pre_next = 6'h00;
            if (div_reg >= divisor) begin
                div_next   = 8'h00;
                quart_next = quart_reg + 2'h1;
                tick_next  = (quart_reg == smcs_pkg::QUART_LAST);
            end else begin
                div_next = div_reg + 8'h01;
            end
        end else begin
            pre_next = pre_reg + 6'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg   <= 6'h00;
            div_reg   <= 8'h00;
            quart_reg <= 2'h0;
            tick_reg  <= 1'b0;
        end else begin
            pre_reg   <= pre_next;
            div_reg   <= div_next;
            quart_reg <= quart_next;
            tick_reg  <= tick_next;
        end
    end

    assign tick = tick_reg;

    a_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
        tick_reg |=> !tick_reg)
        else $error("baud tick longer than one cycle");
endmodule

// File: verification/smcs_far_tx.sv
`timescale 1ns/1ps
module smcs_far_tx #(
    parameter int BIT_CLKS = 64
) (
    input  wire logic pclk,
    output logic      rxd,
    output logic      sck_in
);
    initial begin
        rxd    = 1'b1;
        // no external clock is offered, so the pin rests high
        sck_in = 1'b1;
    end
    // a low stop level lets the bench provoke framing and break faults
    task automatic send_char(input logic [7:0] d, input logic stop,
                             input logic ext = 1'b0);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            for (int k = 0; k < BIT_CLKS; k++) begin
                // sixteen rising edges per bit, clock still between frames
                if (ext) sck_in <= k[1];
                @(posedge pclk);
            end
        end
        rxd <= 1'b1;
        repeat (BIT_CLKS) @(posedge pclk);
    endtask
endmodule

// File: verification/serial_mode_clock_select_tb_top.sv
`timescale 1ns/1ps
module serial_mode_clock_select_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        sck_in;
    logic        sck_out;
    logic        sck_oe;
    logic [1:0]  timer_clk_sel;
    logic [31:0] rd;
    logic        err;
    int          n_errors = 0;
    int          checked = 0;
    int          cyc = 0;
    // control, mode, ctrl, expected status bits 14:8
    localparam logic [31:0] rows [6] = '{32'hf804_0000, 32'h0424_0148,
        32'h0368_0236, 32'h06ec_0141, 32'h0580_0321, 32'h0000_0320};

    smcs_top smcs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rxd, .sck_in,
        .sck_out, .sck_oe, .timer_clk_sel);
    smcs_far_tx smcs_far_tx_inst (.pclk, .rxd, .sck_in);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
            n_errors++;
        end
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [7:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {14'h0000, idx, 2'b00};
        pwdata  <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake or receiver ends here
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            complete_run;
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        repeat (12) @(posedge pclk);
        chk({26'h000_0000, pready, pslverr, sck_out, sck_oe,
             timer_clk_sel}, 32'h0000_0008);
        chk(prdata, 32'h0000_0000);
        presetn <= 1'b1;
        apb(1'b0, smcs_pkg::STC_IDX, 8'h00);
        chk(rd, 32'h0000_00f8);
        foreach (rows[i]) begin
            apb(1'b1, smcs_pkg::STC_IDX, rows[i][31:24]);
            apb(1'b1, smcs_pkg::MODE_IDX, rows[i][23:16]);
            apb(1'b1, smcs_pkg::CTRL_IDX, rows[i][15:8]);
            apb(1'b0, smcs_pkg::STC_IDX, 8'h00);
            chk(rd, 32'(rows[i][31:24] | 8'hf8));
            chk(32'(timer_clk_sel), 32'(rows[i][25:24]));
            apb(1'b0, smcs_pkg::STATUS_IDX, 8'h00);
            chk(32'(rd[14:8]), 32'(rows[i][6:0]));
            chk(32'(sck_oe), 32'(rows[i][6]));
        end
        apb(1'b0, 16'h0001, 8'h00);
        chk(32'(err), 32'h0000_0001);
        apb(1'b1, smcs_pkg::BAUD_IDX, 8'h00);
        apb(1'b1, smcs_pkg::MODE_IDX, 8'h00);
        apb(1'b1, smcs_pkg::STC_IDX, 8'hf8);
        apb(1'b1, smcs_pkg::CTRL_IDX, 8'h10);
        smcs_far_tx_inst.send_char(8'ha5, 1'b1);
        apb(1'b0, smcs_pkg::STATUS_IDX, 8'h00);
        chk(32'(rd[5:0]), 32'h0000_0001);
        apb(1'b0, smcs_pkg::RXDATA_IDX, 8'h00);
        chk(rd, 32'h0000_00a5);
        smcs_far_tx_inst.send_char(8'h3c, 1'b1);
        smcs_far_tx_inst.send_char(8'h0f, 1'b1);
        apb(1'b0, smcs_pkg::STATUS_IDX, 8'h00);
        chk(32'(rd[1:0]), 32'h0000_0003);
        apb(1'b0, smcs_pkg::RXDATA_IDX, 8'h00);
        chk(rd, 32'h0000_003c);
        apb(1'b1, smcs_pkg::STATUS_IDX, 8'h1e);
        smcs_far_tx_inst.send_char(8'h00, 1'b0);
        apb(1'b0, smcs_pkg::STATUS_IDX, 8'h00);
        chk(32'(rd[4:2]), 32'h0000_0005);
        apb(1'b0, smcs_pkg::RXDATA_IDX, 8'h00);
        chk(rd, 32'h0000_0000);
        apb(1'b1, smcs_pkg::STATUS_IDX, 8'h1e);
        apb(1'b1, smcs_pkg::MODE_IDX, 8'h40);
        apb(1'b1, smcs_pkg::CTRL_IDX, 8'h12);
        // seven data bits: bit 7 of the byte lands in the stop slot
        smcs_far_tx_inst.send_char(8'hd5, 1'b1, 1'b1);
        apb(1'b0, smcs_pkg::STATUS_IDX, 8'h00);
        chk(32'(rd[5:0]), 32'h0000_0001);
        apb(1'b0, smcs_pkg::RXDATA_IDX, 8'h00);
        chk(rd, 32'h0000_0055);
        complete_run;
    end
endmodule
